// File: core/adcd_chain.sv
`include "adcd_defines.svh"
`default_nettype none
module adcd_chain
  import adcd_pkg::*;
#(
  parameter int unsigned RESULT_W    = `ADCD_RESULT_W,
  parameter int unsigned CONV_CYCLES = `ADCD_CONV_CYCLES
)
(
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                convert_start,
  input  wire logic                serial_clk,
  input  wire logic                chain_in,
  input  wire logic [RESULT_W-1:0] sample_data,
  output logic                     serial_out,
  output logic                     conv_active,
  output logic                     daisy_mode,
  output logic                     busy_mode,
  output logic                     acq_powerdown
);
  // Refuse shapes the logic cannot serve, at elaboration
  if (RESULT_W < 2)
  begin : g_bad_width
    $error("RESULT_W must be at least 2");
  end
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535)
  begin : g_bad_count
    $error("CONV_CYCLES must be 1 to 65535");
  end

  logic cs_s;
  logic sck_s;
  logic din_s;

  // Pin inputs cross into the core clock domain
  adcd_sync u_sync_cs
  (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .raw_in     (convert_start),
    .stable_out (cs_s)
  );

  adcd_sync u_sync_sck
  (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .raw_in     (serial_clk),
    .stable_out (sck_s)
  );

  adcd_sync u_sync_din
  (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .raw_in     (chain_in),
    .stable_out (din_s)
  );

  adcd_state_t             state_reg;
  adcd_state_t             state_next;
  logic                    cs_d_reg;
  logic                    sck_d_reg;
  logic                    din_d_reg;
  logic [`ADCD_CNT_W-1:0]  cnt_reg;
  logic [`ADCD_CNT_W-1:0]  cnt_next;
  logic [RESULT_W-1:0]     sample_reg;
  logic [RESULT_W-1:0]     sample_next;
  logic [RESULT_W-1:0]     shreg_reg;
  logic [RESULT_W-1:0]     shreg_next;
  logic                    dout_reg;
  logic                    dout_next;
  logic                    busy_reg;
  logic                    busy_next;
  logic                    busy_pend_reg;
  logic                    busy_pend_next;
  logic                    daisy_reg;
  logic                    daisy_next;
  logic                    acq_reg;
  logic                    acq_next;
  logic                    cs_rise;
  logic                    sck_fall;
  logic                    conv_done;

  // Edges of the synchronised pins, and the last cycle of a conversion
  assign cs_rise   = cs_s && !cs_d_reg;
  assign sck_fall  = !sck_s && sck_d_reg;
  assign conv_done = (state_reg == ADCD_CONV) && (cnt_reg == '0);

  // Next state of the conversion and readout sequence
  always_comb
  begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    sample_next    = sample_reg;
    shreg_next     = shreg_reg;
    dout_next      = dout_reg;
    busy_next      = busy_reg;
    busy_pend_next = busy_pend_reg;
    daisy_next     = daisy_reg;
    acq_next       = acq_reg;
    case (state_reg)
      ADCD_IDLE, ADCD_SHIFT:
      begin
        // Previous chain level is used so a chain input tied to start still counts as low
        if (cs_rise && !din_d_reg)
        begin
          state_next  = ADCD_CONV;
          daisy_next  = 1'b1;
          busy_next   = sck_d_reg;
          sample_next = sample_data;
          cnt_next    = `ADCD_CNT_W'(CONV_CYCLES - 1);
          acq_next    = 1'b0;
        end
        else if (state_reg == ADCD_SHIFT && !cs_s)
        begin
          state_next     = ADCD_IDLE;
          busy_pend_next = 1'b0;
        end
        else if (state_reg == ADCD_SHIFT && sck_fall)
        begin
          if (busy_pend_reg)
          begin
            // Upstream busy bit is skipped, own MSB goes out
            busy_pend_next = 1'b0;
            dout_next      = shreg_reg[RESULT_W-1];
          end
          else
          begin
            shreg_next = {shreg_reg[RESULT_W-2:0], din_s};
            dout_next  = shreg_reg[RESULT_W-2];
          end
        end
      end
      ADCD_CONV:
      begin
        // Serial clock is ignored until the count expires
        if (cnt_reg == '0)
        begin
          state_next = ADCD_SHIFT;
          shreg_next = sample_reg;
          acq_next   = 1'b1;
          if (busy_reg)
          begin
            dout_next      = 1'b1;
            busy_pend_next = 1'b1;
          end
          else
          begin
            dout_next = sample_reg[RESULT_W-1];
          end
        end
        else
        begin
          cnt_next = cnt_reg - `ADCD_CNT_W'(1);
        end
      end
      default:
      begin
        state_next = ADCD_IDLE;
      end
    endcase
    // Both inputs low pull the output low in every state
    if (!cs_s && !din_s)
      dout_next = 1'b0;
  end

  // Registers of the sequence
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg     <= ADCD_IDLE;
      cs_d_reg      <= 1'b0;
      sck_d_reg     <= 1'b0;
      din_d_reg     <= 1'b0;
      cnt_reg       <= '0;
      sample_reg    <= '0;
      shreg_reg     <= '0;
      dout_reg      <= 1'b0;
      busy_reg      <= 1'b0;
      busy_pend_reg <= 1'b0;
      daisy_reg     <= 1'b0;
      acq_reg       <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      cs_d_reg      <= cs_s;
      sck_d_reg     <= sck_s;
      din_d_reg     <= din_s;
      cnt_reg       <= cnt_next;
      sample_reg    <= sample_next;
      shreg_reg     <= shreg_next;
      dout_reg      <= dout_next;
      busy_reg      <= busy_next;
      busy_pend_reg <= busy_pend_next;
      daisy_reg     <= daisy_next;
      acq_reg       <= acq_next;
    end
  end

  // Outputs from flip-flops; conv_active is decoded from the state register
  assign serial_out    = dout_reg;
  assign conv_active   = (state_reg == ADCD_CONV);
  assign daisy_mode    = daisy_reg;
  assign busy_mode     = busy_reg;
  assign acq_powerdown = acq_reg;

  // Checks on the sequence
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_both_low_out: assert property ((!cs_s && !din_s) |=> !dout_reg)
    else $error("output not low with both inputs low");
  a_start_daisy: assert property ((state_reg != ADCD_CONV && cs_rise && !din_d_reg)
    |=> (state_reg == ADCD_CONV && daisy_reg && cnt_reg == `ADCD_CNT_W'(CONV_CYCLES - 1)))
    else $error("conversion did not start on start rise");
  a_busy_select: assert property ((state_reg != ADCD_CONV && cs_rise && !din_d_reg)
    |=> busy_reg == $past(sck_d_reg))
    else $error("busy selection not taken from serial clock");
  a_conv_holds: assert property ((state_reg == ADCD_CONV && cnt_reg != '0)
    |=> (state_reg == ADCD_CONV && cnt_reg == $past(cnt_reg) - `ADCD_CNT_W'(1)))
    else $error("conversion left early");
  a_conv_ends: assert property (conv_done |=> (state_reg == ADCD_SHIFT && acq_reg))
    else $error("conversion did not end into acquisition");
  a_msb_first: assert property ((conv_done && !busy_reg && !(!cs_s && !din_s))
    |=> (dout_reg == $past(sample_reg[RESULT_W-1]) && shreg_reg == $past(sample_reg)))
    else $error("MSB not shown at conversion end");
  a_busy_high: assert property ((conv_done && busy_reg && !(!cs_s && !din_s))
    |=> (dout_reg && busy_pend_reg))
    else $error("busy level not driven at conversion end");
  a_shift_capture: assert property ((state_reg == ADCD_SHIFT && cs_s && !cs_rise
    && sck_fall && !busy_pend_reg)
    |=> (shreg_reg[0] == $past(din_s) && dout_reg == $past(shreg_reg[RESULT_W-2])))
    else $error("shift did not capture chain input");
  a_busy_drop: assert property ((state_reg == ADCD_SHIFT && cs_s && !cs_rise
    && sck_fall && busy_pend_reg) |=> (shreg_reg == $past(shreg_reg) && !busy_pend_reg))
    else $error("upstream busy bit was captured");

  // Main scenarios: plain read, busy read, tied start, frame end
  c_read_plain: cover property (conv_done && !busy_reg ##[1:64] sck_fall);
  c_read_busy: cover property (conv_done && busy_reg ##[1:64] (sck_fall && busy_pend_reg));
  c_tied_start: cover property (cs_rise && din_s && !din_d_reg);
  c_frame_end: cover property (state_reg == ADCD_SHIFT && !cs_s && !din_s);
endmodule : adcd_chain
`default_nettype wire

// File: core/adcd_defines.svh
// Notes on behaviour
// - Chain input low at the conversion-start rise, or tied to it, selects daisy-chain.
// - Chain input and conversion-start both low drive the serial output low.
// - Conversion-start rise with chain input low samples input and starts conversion.
// - A started conversion runs to its end regardless of the serial clock.
// - Serial clock low at the conversion-start rise means no busy bit.
// - Serial clock high at the conversion-start rise means a busy bit at the end.
// - No busy bit: load result into 18-bit register and show its MSB at once.
// - Busy bit: load result and drive the serial output high.
// - After conversion every device enters acquisition and power-down.
// - Each readout fall captures the chain input and shifts out the next bit, except the fall that drops a pending busy bit.
// - No busy bit: host gives 18 falls per device, last device first, MSB first.
// - Busy bit: host gets the busy bit first, then 18 falls per device.
// - Upstream busy bits are not captured into the next device's stream.
`ifndef ADCD_DEFINES_SVH
`define ADCD_DEFINES_SVH
`define ADCD_RESULT_W    18
`define ADCD_CONV_CYCLES 200
`define ADCD_CNT_W       16
`endif

// File: core/adcd_pkg.sv
`default_nettype none
package adcd_pkg;
  typedef enum logic [2:0] {
    ADCD_IDLE  = 3'b001,
    ADCD_CONV  = 3'b010,
    ADCD_SHIFT = 3'b100
  } adcd_state_t;
endpackage : adcd_pkg
`default_nettype wire

// File: core/adcd_sync.sv
`default_nettype none
module adcd_sync
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic raw_in,
  output logic      stable_out
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic stable_reg;
  logic stable_next;

  // Accept a new level only once the second and third stages agree
  always_comb
  begin
    stable_next = (ff2_reg == ff3_reg) ? ff2_reg : stable_reg;
  end

  // Three-stage synchroniser chain
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ff1_reg    <= 1'b0;
      ff2_reg    <= 1'b0;
      ff3_reg    <= 1'b0;
      stable_reg <= 1'b0;
    end
    else
    begin
      ff1_reg    <= raw_in;
      ff2_reg    <= ff1_reg;
      ff3_reg    <= ff2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable_out = stable_reg;
endmodule : adcd_sync
`default_nettype wire

// File: tb/adcd_host_model.sv
`default_nettype none
module adcd_host_model
(
  input  wire logic core_clk,
  input  wire logic serial_out,
  output var logic  convert_start,
  output var logic  serial_clk,
  output var logic  chain_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [36:0] got;
  // Pins idle low; serial clock stands still between frames
  initial
  begin
    convert_start = 1'b0;
    serial_clk    = 1'b0;
    chain_in      = 1'b0;
    got           = '0;
  end
  // Half of the 64 ns serial period
  task automatic half();
    repeat (8) @(negedge core_clk);
  endtask : half
  // Raise start with the chosen clock level; tie copies start onto the chain input
  task automatic start(input logic lvl, input logic tie);
    serial_clk = lvl;
    chain_in = 1'b0;
    half();
    convert_start = 1'b1;
    chain_in = tie;
  endtask : start
  // Sample each bit just before its fall; up plays the upstream output
  task automatic read(input int n, input logic [36:0] up);
    for (int j = 0; j < n; j++)
    begin
      serial_clk = 1'b1;
      chain_in = up[36-j];
      half();
      got[36-j] = serial_out;
      serial_clk = 1'b0;
      half();
    end
  endtask : read
  // End the frame: start and chain input low together
  task automatic stop();
    chain_in = 1'b0;
    convert_start = 1'b0;
    half();
  endtask : stop
endmodule : adcd_host_model
`default_nettype wire

// File: tb/tb_adcd_chain.sv
`default_nettype none
module tb_adcd_chain;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 64;
  logic        core_clk    = 1'b0;
  logic        sys_rst     = 1'b1;
  logic [17:0] sample_data = 18'h0;
  wire logic   convert_start, serial_clk, chain_in, serial_out;
  wire logic   conv_active, daisy_mode, busy_mode, acq_powerdown;
  int          errors      = 0;
  int          compares    = 0;
  // Device under test and host
  adcd_chain #(.RESULT_W(18), .CONV_CYCLES(CONV)) adcd_chain_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .convert_start(convert_start), .serial_clk(serial_clk),
    .chain_in(chain_in), .sample_data(sample_data), .serial_out(serial_out),
    .conv_active(conv_active), .daisy_mode(daisy_mode), .busy_mode(busy_mode),
    .acq_powerdown(acq_powerdown));
  adcd_host_model adcd_host_model_inst (.core_clk(core_clk), .serial_out(serial_out),
    .convert_start(convert_start), .serial_clk(serial_clk), .chain_in(chain_in));
  // Core clock
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Time the conversion and look at the outputs at its end
  task automatic conv_check(input logic bz, input logic first);
    int n;
    n = 0;
    while (conv_active !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(37'(acq_powerdown), 37'(0));
    n = 0;
    while (conv_active === 1'b1 && n < 500)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(37'(n), 37'(CONV));
    chk(37'(acq_powerdown), 37'(1));
    chk(37'(serial_out), 37'(first));
    chk(37'(busy_mode), 37'(bz));
    chk(37'(daisy_mode), 37'(1));
  endtask : conv_check
  // No busy bit, two devices, serial clock toggling during conversion
  task automatic t_plain();
    sample_data = 18'h2b5c3;
    adcd_host_model_inst.start(1'b0, 1'b0);
    fork
      conv_check(1'b0, 1'b1);
      repeat (4)
      begin
        adcd_host_model_inst.half();
        adcd_host_model_inst.serial_clk = ~adcd_host_model_inst.serial_clk;
      end
    join
    adcd_host_model_inst.read(36, {18'h1a9e4, 19'h0});
    chk({1'b0, adcd_host_model_inst.got[36:1]}, {1'b0, 18'h2b5c3, 18'h1a9e4});
    adcd_host_model_inst.stop();
    chk(37'(serial_out), 37'(0));
  endtask : t_plain
  // Busy bit, upstream busy bit on the chain input at the first fall
  task automatic t_busy();
    sample_data = 18'h0d2a7;
    adcd_host_model_inst.start(1'b1, 1'b0);
    conv_check(1'b1, 1'b1);
    adcd_host_model_inst.read(37, {1'b1, 18'h3365c, 18'h0});
    chk(adcd_host_model_inst.got, {1'b1, 18'h0d2a7, 18'h3365c});
    adcd_host_model_inst.stop();
  endtask : t_busy
  // First device with chain input tied to start
  task automatic t_tied();
    sample_data = 18'h15a5a;
    adcd_host_model_inst.start(1'b1, 1'b1);
    conv_check(1'b1, 1'b1);
    adcd_host_model_inst.read(37, '1);
    chk(adcd_host_model_inst.got, {1'b1, 18'h15a5a, 18'h3ffff});
    adcd_host_model_inst.stop();
  endtask : t_tied
  // Start rise with chain input high is not taken
  task automatic t_refuse();
    adcd_host_model_inst.chain_in = 1'b1;
    adcd_host_model_inst.half();
    adcd_host_model_inst.convert_start = 1'b1;
    repeat (30) @(negedge core_clk);
    chk(37'(conv_active), 37'(0));
    adcd_host_model_inst.stop();
  endtask : t_refuse
  // Main sequence
  initial
  begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(37'(conv_active), 37'(0));
    chk(37'(daisy_mode), 37'(0));
    chk(37'(acq_powerdown), 37'(0));
    chk(37'(serial_out), 37'(0));
    t_plain();
    t_busy();
    t_tied();
    t_refuse();
    end_sim();
  end
  // Watchdog
  initial
  begin
    #100000;
    errors++;
    end_sim();
  end
endmodule : tb_adcd_chain
`default_nettype wire
